/* ebd_pkg.sv */
// Shared constants and carrier types for the external bus decoder.
// Assumes a single 100 MHz system clock and pins sampled by the decoder core.
`default_nettype none

package ebd_pkg;

  // System clock period and the shortest controller reset pulse.
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned RESET_PULSE_NS     = 5000;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W        = 10;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(RESET_PULSE_CYCLES);
  localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO = 10'h000;

  // Region select field: the top three address lines.
  localparam int unsigned REGION_LSB = 13;
  localparam int unsigned REGION_W   = 3;
  localparam int unsigned NUM_STROBES = 7;

  // Region numbers of the documented map.
  localparam logic [REGION_W-1:0] REGION_KEYPAD_LATCH = 3'h0;
  localparam logic [REGION_W-1:0] REGION_IO_LATCH     = 3'h1;
  localparam logic [REGION_W-1:0] REGION_EEPROM       = 3'h7;

  // Latch offsets and the top of the always-writable EEPROM window.
  localparam logic [15:0] KEYPAD_LATCH_OFFSET = 16'h0000;
  localparam logic [15:0] IO_LATCH_OFFSET     = 16'h2000;
  localparam logic [15:0] EEPROM_OPEN_TOP     = 16'hE1FF;

  // Values after reset.
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // Pins from the controller and the programming connector.
  typedef struct packed {
    logic       program_store_enable_n;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic       eeprom_write_unlock_n;
    logic       boot_mode_detect;
    logic [7:0] addr_high;
    logic [7:0] muxed_bus;
  } ebd_pins_type;

  localparam ebd_pins_type PINS_IDLE = '{
    program_store_enable_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
    eeprom_write_unlock_n: 1'b1, boot_mode_detect: 1'b0,
    addr_high: 8'h00, muxed_bus: 8'h00};

  // Active-low chip selects and strobes; strobe bit n serves region n.
  typedef struct packed {
    logic                   program_flash_sel_n;
    logic                   eeprom_read_sel_n;
    logic                   eeprom_write_guard;
    logic [NUM_STROBES-1:0] decoder_write_select;
  } ebd_select_type;

  localparam ebd_select_type SELECT_IDLE = '{
    program_flash_sel_n: 1'b1, eeprom_read_sel_n: 1'b1,
    eeprom_write_guard: 1'b1, decoder_write_select: 7'h7F};

endpackage : ebd_pkg

`default_nettype wire

/* ebd_octal_latch.sv */
// Octal output latch loading on the low-to-high edge of its write strobe.
// Assumes strobe and data come from flip-flops on the same clock.
`default_nettype none
`timescale 1ns/1ps

module ebd_octal_latch (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       strobe_n,
  input  wire logic [7:0] data,
  output var  logic [7:0] q
);
  import ebd_pkg::*;

  typedef struct packed {
    logic       strobe_prev;
    logic [7:0] q;
  } ebd_latch_state_type;

  ebd_latch_state_type state_reg;
  ebd_latch_state_type state_next;

  // Load on the strobe's rising edge, otherwise hold the last byte.
  always_comb
  begin
    state_next = state_reg;
    state_next.strobe_prev = strobe_n;
    if (strobe_n && !state_reg.strobe_prev)
    begin
      state_next.q = data;
    end
  end

  // Reset gives a known byte; software must not rely on it.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '{strobe_prev: 1'b1, q: LATCH_RESET};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.q;

endmodule // ebd_octal_latch

`default_nettype wire

/* ebd_decoder.sv */
// External bus decoder: region selects, EEPROM write guard, output latches
// and the boot-mode reset pulse. Assumes every pin arrives asynchronously.
`default_nettype none
`timescale 1ns/1ps

// Timing, counted in system clock edges from a pin change:
// - every pin passes two synchroniser flops and one decode flop, so a select
//   answers on the third edge and stands for as long as its condition holds;
// - the low address byte is taken one edge after the synchronised latch
//   enable is seen low, so the decode of a new address follows the enable;
// - a latch loads one edge after its write select returns high, from the last
//   bus byte seen while the write strobe was low;
// - the controller reset pulse restarts on every boot detect transition.
// Limitations: the selects lag the pins by three edges, so a bus cycle that
// holds its strobe for fewer than two edges may be missed or shortened; and a
// pin glitch shorter than a clock period can still give a one-cycle select,
// which the board's gates would not stretch.
// The trade is latency for safety: no pin reaches decode logic unsynchronised.

module ebd_decoder (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire ebd_pkg::ebd_pins_type bus_pins,
  output var  ebd_pkg::ebd_select_type select_out,
  output var  logic [7:0]            keypad_latch_q,
  output var  logic [7:0]            io_latch_q,
  output var  logic                  boot_mode,
  output var  logic                  controller_reset
);
  import ebd_pkg::*;

  // Every bit of state but the two latches lives here, grouped by job.
  typedef struct packed {
    // Two synchroniser stages for every pin.
    ebd_pins_type           pins_meta;
    ebd_pins_type           pins_sync;
    // Low address capture on the falling latch enable.
    logic                   ale_prev;
    logic [7:0]             low_addr;
    // Boot detect edge finder and reset pulse timer.
    logic                   boot_prev;
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    logic                   ctl_reset;
    logic                   boot_mode;
    // Data byte for the latches and the registered selects.
    logic [7:0]             write_data;
    ebd_select_type         sel;
  } ebd_state_type;

  // Registered state and the value it takes at the next edge.
  ebd_state_type state_reg;
  ebd_state_type state_next;

  // Decode terms taken from the synchronised pins.
  logic [15:0]         full_addr;
  logic [REGION_W-1:0] region;
  logic                eeprom_open;
  logic                fetch_req;
  logic                read_req;
  logic                write_req;
  logic                eeprom_region;

  // Full address is the held high byte plus the latched low byte.
  always_comb
  begin
    full_addr = {state_reg.pins_sync.addr_high, state_reg.low_addr};
    region = full_addr[REGION_LSB +: REGION_W];
    eeprom_open = (full_addr <= EEPROM_OPEN_TOP);
    // The bus strobes are active low at the pins; turn them into requests once
    // so that every select below reads the same polarity.
    fetch_req = !state_reg.pins_sync.program_store_enable_n;
    read_req  = !state_reg.pins_sync.rd_n;
    write_req = !state_reg.pins_sync.wr_n;
    // The EEPROM owns the whole top region for reads and for guarded writes.
    eeprom_region = (region == REGION_EEPROM);
  end

  // Next-state logic for the whole decoder.
  always_comb
  begin
    state_next = state_reg;

    // Pins pass two flops before anything reads them.
    state_next.pins_meta = bus_pins;
    state_next.pins_sync = state_reg.pins_meta;
    state_next.ale_prev  = state_reg.pins_sync.ale;

    // ALE falling edge
    // The address latch on the board is transparent while the enable is high;
    // only the falling edge fixes the byte, so one capture there is enough.
    if (state_reg.ale_prev && !state_reg.pins_sync.ale)
    begin
      state_next.low_addr = state_reg.pins_sync.muxed_bus;
    end

    state_next.sel.program_flash_sel_n = !fetch_req;

    // EEPROM read region
    // Reads anywhere else select nothing; the controller then sees a floating bus.
    state_next.sel.eeprom_read_sel_n = !(read_req && eeprom_region);

    // Low 512 bytes open
    // A blocked write is simply swallowed: the controller finishes a normal bus
    // cycle and gets no sign that the byte was not stored.
    state_next.sel.eeprom_write_guard =
      !(write_req && eeprom_region &&
        (eeprom_open || !state_reg.pins_sync.eeprom_write_unlock_n));

    // Track bus data during write
    // Following the bus for the whole strobe low time and keeping the last byte
    // gives the level present just before the strobe rises, as the latch needs.
    if (write_req)
    begin
      state_next.write_data = state_reg.pins_sync.muxed_bus;
    end

    // Boot mode follows detect
    // A plain level copy; the reset pulse below keeps the controller quiet
    // while the mode settles.
    state_next.boot_mode = state_reg.pins_sync.boot_mode_detect;
    state_next.boot_prev = state_reg.pins_sync.boot_mode_detect;

    // Pulse on either edge
    // The count restarts on each transition, so a bouncing detect line
    // stretches the pulse instead of chopping it into pulses that are too short.
    if (state_reg.boot_prev != state_reg.pins_sync.boot_mode_detect)
    begin
      state_next.pulse_cnt = PULSE_LOAD;
    end
    else if (state_reg.pulse_cnt != PULSE_ZERO)
    begin
      state_next.pulse_cnt = state_reg.pulse_cnt - 10'h001;
    end
    state_next.ctl_reset = (state_next.pulse_cnt != PULSE_ZERO);

    // Write strobes below the EEPROM region, one per region.
    // Region 7 has no strobe bit; its writes go through the guard instead.
    for (int i = 0; i < NUM_STROBES; i++)
    begin
      state_next.sel.decoder_write_select[i] =
        !(write_req && (region == REGION_W'(i)));
    end
  end

  // All state but the two latches registered here; reset leaves every select inactive.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // Pins reset to their idle levels, so no false edge follows reset.
      state_reg <= '{pins_meta:  PINS_IDLE,
                     pins_sync:  PINS_IDLE,
                     ale_prev:   1'b0,
                     low_addr:   8'h00,
                     boot_prev:  1'b0,
                     pulse_cnt:  PULSE_ZERO,
                     ctl_reset:  1'b0,
                     boot_mode:  1'b0,
                     write_data: 8'h00,
                     sel:        SELECT_IDLE};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Two latches differ only in their strobe, so one loop builds both.
  // Only regions 0 and 1 carry latches; the five board selects leave the
  // block as strobes for the far side to use.
  logic [1:0][7:0] latch_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_latch
      // Latch per strobe
      // The strobe comes straight from a flop, so the edge finder inside the
      // latch sees one clean rising edge per write.
      ebd_octal_latch u_latch (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .strobe_n (state_reg.sel.decoder_write_select[g]),
        .data     (state_reg.write_data),
        .q        (latch_q[g])
      );
    end
  endgenerate

  // Every output comes straight from a flop.
  assign select_out       = state_reg.sel;
  assign keypad_latch_q   = latch_q[1'(REGION_KEYPAD_LATCH)];
  assign io_latch_q       = latch_q[1'(REGION_IO_LATCH)];
  assign boot_mode        = state_reg.boot_mode;
  assign controller_reset = state_reg.ctl_reset;

endmodule // ebd_decoder

`default_nettype wire

/* ebd_decoder_monitor.sv */
// Checker on the decoder ports: selects, latches and the boot reset pulse.
// Assumes pins reach the decode outputs three clock edges after they change.
`timescale 1ns/1ps
`default_nettype none
module ebd_decoder_monitor (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire ebd_pkg::ebd_pins_type   bus_pins,
  input wire ebd_pkg::ebd_select_type select_out,
  input wire logic [7:0]              keypad_latch_q,
  input wire logic [7:0]              io_latch_q,
  input wire logic                    boot_mode,
  input wire logic                    controller_reset
);
  import ebd_pkg::*;
  ebd_pins_type [2:0] dly_reg;
  ebd_pins_type       p;
  logic [10:0]        len_reg;
  logic [2:0]         rg;
  logic               wr;
  // Pin copies line up with the decode latency, so each check compares like with like.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dly_reg <= {3{PINS_IDLE}};
      len_reg <= 11'h000;
    end
    else
    begin
      dly_reg <= {dly_reg[1:0], bus_pins};
      len_reg <= controller_reset ? len_reg + 11'h001 : 11'h000;
    end
  end
  // Region and write request as the decoder saw them one edge ago.
  assign p  = dly_reg[2];
  assign rg = p.addr_high[7:5];
  assign wr = !p.wr_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_flash_fetch: assert property (select_out.program_flash_sel_n == p.program_store_enable_n)
    else $error("flash select wrong");
  chk_eeprom_read: assert property (select_out.eeprom_read_sel_n == !(!p.rd_n && rg == 3'h7))
    else $error("eeprom read select wrong");
  chk_region_strobe: assert property (
    select_out.decoder_write_select == ((wr && rg != 3'h7) ? ~(7'h01 << rg) : 7'h7F))
    else $error("region strobe wrong");
  chk_guard_block: assert property (
    select_out.eeprom_write_guard == !(wr && rg == 3'h7 && (p.addr_high <= 8'hE1 || !p.eeprom_write_unlock_n)))
    else $error("eeprom write guard wrong");
  chk_latch_load: assert property (
    $rose(select_out.decoder_write_select[1]) |-> ##2 io_latch_q == $past(bus_pins.muxed_bus, 5))
    else $error("io latch load wrong");
  chk_latch_hold: assert property (select_out.decoder_write_select[0] [*4] |-> $stable(keypad_latch_q))
    else $error("keypad latch moved");
  chk_pulse_start: assert property ($changed(bus_pins.boot_mode_detect) |-> ##3 controller_reset)
    else $error("reset pulse missing");
  chk_pulse_len: assert property ($fell(controller_reset) |-> len_reg >= 11'(RESET_PULSE_CYCLES))
    else $error("reset pulse short");
  chk_boot_level: assert property (boot_mode == p.boot_mode_detect)
    else $error("boot mode wrong");
  cover property ($fell(select_out.eeprom_write_guard));
  cover property ($fell(select_out.decoder_write_select[6]));
  cover property ($fell(controller_reset));
endmodule // ebd_decoder_monitor
bind ebd_decoder ebd_decoder_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .bus_pins(bus_pins),
  .select_out(select_out), .keypad_latch_q(keypad_latch_q), .io_latch_q(io_latch_q),
  .boot_mode(boot_mode), .controller_reset(controller_reset));
`default_nettype wire

/* ebd_ctrl_model.sv */
// Controller model driving the multiplexed bus and the cable lines.
// Assumes its tasks are called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module ebd_ctrl_model (
  input wire logic                  clk_sys,
  output var ebd_pkg::ebd_pins_type bus_pins
);
  import ebd_pkg::*;
  // Idle bus from time zero.
  initial bus_pins = PINS_IDLE;
  // Cable line held for the access, low byte on the bus while the latch enable pulses.
  task automatic access(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data, input logic ul_n);
    @(posedge clk_sys);
    bus_pins.eeprom_write_unlock_n <= ul_n;
    bus_pins.ale <= 1'b1;
    bus_pins.addr_high <= addr[15:8];
    bus_pins.muxed_bus <= addr[7:0];
    repeat (2) @(posedge clk_sys);
    bus_pins.ale <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // Data byte settles a cycle before the strobe drops.
    bus_pins.muxed_bus <= data;
    @(posedge clk_sys);
    bus_pins.program_store_enable_n <= (kind != 2'h0);
    bus_pins.rd_n <= (kind != 2'h1);
    bus_pins.wr_n <= (kind != 2'h2);
    repeat (5) @(posedge clk_sys);
  endtask
  // Strobes rise first; the byte is then replaced by its inverse so a stale value never looks valid.
  task automatic release_bus(input logic [7:0] data);
    @(posedge clk_sys);
    bus_pins.program_store_enable_n <= 1'b1;
    bus_pins.rd_n <= 1'b1;
    bus_pins.wr_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    bus_pins.muxed_bus <= ~data;
  endtask
  // Boot detect level from the cable.
  task automatic set_boot(input logic b);
    @(posedge clk_sys);
    bus_pins.boot_mode_detect <= b;
  endtask
endmodule // ebd_ctrl_model
`default_nettype wire

/* tb_external_bus_decoder.sv */
// Self-checking bench for the external bus decoder.
// Assumes the controller model above and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_external_bus_decoder;
  import ebd_pkg::*;
  logic           clk_sys;
  logic           rst;
  ebd_pins_type   bus_pins;
  ebd_select_type select_out;
  logic [7:0]     keypad_latch_q;
  logic [7:0]     io_latch_q;
  logic           boot_mode;
  logic           controller_reset;
  int             n_fail = 0;
  int             checks_done = 0;
  logic [7:0]     exp_kp = LATCH_RESET;
  logic [7:0]     exp_io = LATCH_RESET;
  // Row: expected selects {flash, read, guard, strobes[6:0]} in the top 12 bits, then the kind
  // nibble (0 fetch, 1 read, 2 write), address, data byte and unlock_n nibble.
  logic [43:0]    rows [16] = '{44'h1FF_0123_4001, 44'h1FF_0F00_0001, 44'h2FF_1E05_5001,
    44'h3FF_1600_0001, 44'h3FE_2000_0A51, 44'h3FD_2200_05A1, 44'h3FB_2400_0111, 44'h3F7_2600_0221,
    44'h3EF_2800_0331, 44'h3DF_2A00_0441, 44'h3BF_2C00_0551, 44'h37F_2E1F_F661, 44'h3FF_2E20_0771,
    44'h37F_2E20_0880, 44'h3FF_2FFF_F991, 44'h3FE_2000_03C1};
  ebd_decoder i_dut (.clk_sys(clk_sys), .rst(rst), .bus_pins(bus_pins), .select_out(select_out),
    .keypad_latch_q(keypad_latch_q), .io_latch_q(io_latch_q), .boot_mode(boot_mode),
    .controller_reset(controller_reset));
  ebd_ctrl_model i_ctrl (.clk_sys(clk_sys), .bus_pins(bus_pins));
  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Expected selects worked out from the address map of a row.
  function automatic ebd_select_type expect_sel(input logic [31:0] r);
    ebd_select_type e;
    e = SELECT_IDLE;
    e.program_flash_sel_n = (r[31:28] != 4'h0);
    e.eeprom_read_sel_n = !(r[31:28] == 4'h1 && r[27:25] == 3'h7);
    if (r[31:28] == 4'h2 && r[27:25] != 3'h7)
      e.decoder_write_select[r[27:25]] = 1'b0;
    e.eeprom_write_guard = !(r[31:28] == 4'h2 && r[27:25] == 3'h7 && (r[27:12] <= 16'hE1FF || !r[0]));
    return e;
  endfunction
  // One comparison, counted, reported at once on mismatch.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Single place where the run ends.
  task automatic final_report;
    $display("TB: %0d checks, %0d mismatches", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset, table of accesses, then both boot transitions.
  initial
  begin
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("reset state", {SELECT_IDLE, exp_kp, exp_io}, {select_out, keypad_latch_q, io_latch_q});
    foreach (rows[i])
    begin
      i_ctrl.access(rows[i][29:28], rows[i][27:12], rows[i][11:4], rows[i][0]);
      #1;
      check("selects", expect_sel(rows[i][31:0]), select_out);
      check("select table", rows[i][41:32], select_out);
      if (rows[i][31:28] == 4'h2 && rows[i][27:12] == KEYPAD_LATCH_OFFSET)
        exp_kp = rows[i][11:4];
      if (rows[i][31:28] == 4'h2 && rows[i][27:12] == IO_LATCH_OFFSET)
        exp_io = rows[i][11:4];
      i_ctrl.release_bus(rows[i][11:4]);
      #1;
      check("latches", {exp_kp, exp_io}, {keypad_latch_q, io_latch_q});
    end
    for (int v = 1; v >= 0; v--)
    begin
      i_ctrl.set_boot(v[0]);
      repeat (4) @(posedge clk_sys);
      #1;
      check("boot start", {v[0], 1'b1}, {boot_mode, controller_reset});
      repeat (RESET_PULSE_CYCLES - 5) @(posedge clk_sys);
      #1;
      check("pulse held", 1'b1, controller_reset);
      repeat (10) @(posedge clk_sys);
      #1;
      check("pulse end", 1'b0, controller_reset);
    end
    // Reset in mid-run: both latches hold written bytes, which must go back to the reset byte.
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    exp_kp = LATCH_RESET;
    exp_io = LATCH_RESET;
    @(posedge clk_sys);
    #1;
    check("mid-run reset", {SELECT_IDLE, exp_kp, exp_io, 2'b00},
      {select_out, keypad_latch_q, io_latch_q, boot_mode, controller_reset});
    final_report;
  end
  // Watchdog well beyond the expected run of about 1320 cycles.
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end
endmodule // tb_external_bus_decoder
`default_nettype wire
